// file: verilog/can_trx_pkg.sv
package can_trx_pkg;
   localparam logic [7:0] CAN_MODE_CONTROL_ADDR = 8'h20;
   localparam logic [7:0] TRANSCEIVER_STATUS_ADDR = 8'h22;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [1:0] SEL_OFFLINE = 2'h0;
   localparam logic [1:0] SEL_ACTIVE_UV = 2'h1;
   localparam logic [1:0] SEL_ACTIVE_RST = 2'h2;
   localparam logic [1:0] SEL_LISTEN = 2'h3;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 1;
   localparam logic [2:0] CHIP_NORMAL = 3'h7;
   localparam logic [2:0] CHIP_STANDBY = 3'h4;
   localparam logic [2:0] CHIP_RESET = 3'h3;
   localparam logic [2:0] CHIP_OVERTEMP = 3'h2;
   localparam logic [2:0] CHIP_OFF = 3'h0;
   localparam int STAT_ACTIVE_BIT = 7;
   localparam int STAT_SILENCE_BIT = 3;
   localparam int STAT_SUPPLY_BIT = 1;
   localparam int STAT_TIMEOUT_BIT = 0;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SILENCE_TIME_NS = 1000000;
   localparam int WAKE_TIMEOUT_NS = 1000000;
   localparam int WAKE_DOM_MIN_NS = 2000;
   localparam int WAKE_REC_MIN_NS = 2000;
   localparam int TX_DOM_TIME_NS = 3000000;
   // synchroniser lanes: bus, txd, v1<90, v1<reset, vbat uv, vbat recovered
   localparam int SYNC_W = 6;
   localparam logic [5:0] SYNC_RESET = 6'h02;
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_OFFLINE = 3'b001,
      MODE_OFFLINE_BIAS = 3'b011,
      MODE_LISTEN = 3'b010,
      MODE_ACTIVE = 3'b110
   } trx_mode_t;
   typedef enum logic [1:0] {
      WAKE_IDLE = 2'b00,
      WAKE_FIRST_DOM = 2'b01,
      WAKE_RECESSIVE = 2'b11,
      WAKE_SECOND_DOM = 2'b10
   } wake_phase_t;
endpackage : can_trx_pkg

// file: verilog/can_trx_mode_control.sv
`timescale 1ns/1ps
module can_trx_mode_control #(
   parameter int CNT_W = 24,
   parameter int SILENCE_NS = can_trx_pkg::SILENCE_TIME_NS,
   parameter int WAKE_TO_NS = can_trx_pkg::WAKE_TIMEOUT_NS,
   parameter int WAKE_DOM_NS = can_trx_pkg::WAKE_DOM_MIN_NS,
   parameter int WAKE_REC_NS = can_trx_pkg::WAKE_REC_MIN_NS,
   parameter int TX_DOM_NS = can_trx_pkg::TX_DOM_TIME_NS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] chip_mode_code,
   input wire logic bus_dominant,
   input wire logic txd,
   input wire logic v1_below_90,
   input wire logic v1_below_reset,
   input wire logic vbat_undervoltage,
   input wire logic vbat_recovered,
   input wire logic bus_wake_enable,
   input wire logic transceiver_fault_enable,
   input wire logic bus_wake_clear,
   input wire logic fault_event_clear,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output can_trx_pkg::trx_mode_t trx_mode,
   output logic tx_drive_dominant,
   output logic rxd_out,
   output logic bias_half_supply,
   output logic bus_floating,
   output logic bus_wake_flag,
   output logic transceiver_fault_event
);
   import can_trx_pkg::*;

   localparam logic [CNT_W-1:0] SILENCE_CYC = CNT_W'((SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_TO_CYC = CNT_W'(WAKE_TO_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_DOM_CYC = CNT_W'((WAKE_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_REC_CYC = CNT_W'((WAKE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] TX_DOM_CYC = CNT_W'((TX_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic bus_s, txd_s, v1_low90_s, v1_lowrst_s, vbat_uv_s, vbat_rec_s;
   logic bus_prev_reg;
   logic [CNT_W-1:0] silence_cnt_reg;
   logic [CNT_W-1:0] tx_dom_cnt_reg;
   logic [CNT_W-1:0] run_cnt_reg;
   logic [CNT_W-1:0] wake_win_reg;
   logic [7:0] ctrl_reg;
   logic supply_low_status;
   logic tx_timeout_status;
   logic bus_silence_status;
   trx_mode_t mode_reg;
   trx_mode_t mode_next;
   wake_phase_t wake_phase_reg;
   wake_phase_t wake_phase_next;
   logic wake_detect;
   logic [1:0] transceiver_mode_select;
   logic chip_normal, chip_dead, off_cond, sel_active, v1_ok, uv_bias_cond, bus_edge, tx_timeout_hit;
   logic wake_armed, event_pending, fault_hit;

   assign {bus_s, txd_s, v1_low90_s, v1_lowrst_s, vbat_uv_s, vbat_rec_s} = sync2_reg;

   // pins and analog comparators are asynchronous to clk
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync1_reg <= SYNC_RESET;
         sync2_reg <= SYNC_RESET;
      end
      else
      begin
         sync1_reg <= {bus_dominant, txd, v1_below_90, v1_below_reset, vbat_undervoltage, vbat_recovered};
         sync2_reg <= sync1_reg;
      end
   end

   always_comb
   begin
      transceiver_mode_select = ctrl_reg[SEL_MSB:SEL_LSB];
      chip_normal = (chip_mode_code == CHIP_NORMAL);
      chip_dead = (chip_mode_code == CHIP_OFF) || (chip_mode_code == CHIP_OVERTEMP);
      off_cond = chip_dead || vbat_uv_s;
      sel_active = (transceiver_mode_select == SEL_ACTIVE_UV) || (transceiver_mode_select == SEL_ACTIVE_RST);
      v1_ok = (transceiver_mode_select == SEL_ACTIVE_UV) ? !v1_low90_s : !v1_lowrst_s;
      uv_bias_cond = chip_normal && sel_active && v1_low90_s;
      bus_edge = (bus_s != bus_prev_reg);
      tx_timeout_hit = (mode_reg == MODE_ACTIVE) && !txd_s && (tx_dom_cnt_reg >= TX_DOM_CYC);
      wake_armed = (mode_reg == MODE_OFFLINE) && bus_wake_enable;
      event_pending = bus_wake_flag || transceiver_fault_event;
      fault_hit = tx_timeout_hit || ((mode_reg == MODE_ACTIVE) && (transceiver_mode_select == SEL_ACTIVE_UV)
                                     && chip_normal && v1_low90_s);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         bus_prev_reg <= 1'b0;
      else
         bus_prev_reg <= bus_s;
   end

   // silence counter saturates so the flag holds while the bus stays quiet
   always_ff @(posedge clk)
   begin
      if (reset)
         silence_cnt_reg <= CNT_ZERO;
      else if (bus_edge)
         silence_cnt_reg <= CNT_ZERO;
      else if (silence_cnt_reg < SILENCE_CYC)
         silence_cnt_reg <= silence_cnt_reg + CNT_ONE;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         bus_silence_status <= 1'b0;
      else
         bus_silence_status <= (silence_cnt_reg >= SILENCE_CYC) && !bus_edge;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         tx_dom_cnt_reg <= CNT_ZERO;
      else if (txd_s || mode_reg != MODE_ACTIVE)
         tx_dom_cnt_reg <= CNT_ZERO;
      else if (tx_dom_cnt_reg < TX_DOM_CYC)
         tx_dom_cnt_reg <= tx_dom_cnt_reg + CNT_ONE;
   end

   // stays set while the transmitter is held off; a fresh Active entry clears it
   always_ff @(posedge clk)
   begin
      if (reset)
         tx_timeout_status <= 1'b0;
      else if (tx_timeout_hit)
         tx_timeout_status <= 1'b1;
      else if (mode_next == MODE_ACTIVE && mode_reg != MODE_ACTIVE)
         tx_timeout_status <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         supply_low_status <= 1'b0;
      else
         supply_low_status <= (transceiver_mode_select == SEL_ACTIVE_UV) && v1_low90_s;
   end

   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_OFF:
            if (!off_cond && vbat_rec_s)
               mode_next = MODE_OFFLINE;
         MODE_OFFLINE:
            if (wake_detect || uv_bias_cond)
               mode_next = MODE_OFFLINE_BIAS;
            else if (chip_normal && sel_active && v1_ok)
               mode_next = txd_s ? MODE_ACTIVE : MODE_LISTEN;
            else if (chip_normal && transceiver_mode_select == SEL_LISTEN)
               mode_next = MODE_LISTEN;
         MODE_OFFLINE_BIAS:
            if (chip_normal && sel_active && v1_ok)
               mode_next = txd_s ? MODE_ACTIVE : MODE_LISTEN;
            else if (chip_normal && transceiver_mode_select == SEL_LISTEN)
               mode_next = MODE_LISTEN;
            else if (bus_silence_status && !uv_bias_cond)
               mode_next = MODE_OFFLINE;
         MODE_LISTEN:
            if (!chip_normal || transceiver_mode_select == SEL_OFFLINE)
               mode_next = bus_silence_status ? MODE_OFFLINE : MODE_OFFLINE_BIAS;
            else if (sel_active && v1_ok && txd_s)
               mode_next = MODE_ACTIVE;
         MODE_ACTIVE:
            if (!chip_normal || transceiver_mode_select == SEL_OFFLINE || !v1_ok)
               mode_next = bus_silence_status ? MODE_OFFLINE : MODE_OFFLINE_BIAS;
            else if (tx_timeout_hit || transceiver_mode_select == SEL_LISTEN)
               mode_next = MODE_LISTEN;
         default:
            mode_next = MODE_OFF;
      endcase
      if (off_cond)
         mode_next = MODE_OFF;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         mode_reg <= MODE_OFF;
      else
         mode_reg <= mode_next;
   end

   // run length of the current bus level; every bus edge restarts it, however short
   always_ff @(posedge clk)
   begin
      if (reset || bus_edge)
         run_cnt_reg <= CNT_ZERO;
      else if (run_cnt_reg < WAKE_TO_CYC)
         run_cnt_reg <= run_cnt_reg + CNT_ONE;
   end

   always_comb
   begin
      wake_phase_next = wake_phase_reg;
      wake_detect = 1'b0;
      case (wake_phase_reg)
         WAKE_IDLE:
            if (bus_s && run_cnt_reg >= WAKE_DOM_CYC)
               wake_phase_next = WAKE_FIRST_DOM;
         WAKE_FIRST_DOM:
            if (!bus_s)
               wake_phase_next = WAKE_RECESSIVE;
         WAKE_RECESSIVE:
            if (!bus_s && run_cnt_reg >= WAKE_REC_CYC)
               wake_phase_next = WAKE_SECOND_DOM;
         WAKE_SECOND_DOM:
            if (bus_s && run_cnt_reg >= WAKE_DOM_CYC)
            begin
               wake_detect = 1'b1;
               wake_phase_next = WAKE_IDLE;
            end
         default:
            wake_phase_next = WAKE_IDLE;
      endcase
      if (wake_phase_reg != WAKE_IDLE && wake_win_reg >= WAKE_TO_CYC)
      begin
         wake_detect = 1'b0;
         wake_phase_next = WAKE_IDLE;
      end
      if (!wake_armed)
      begin
         wake_detect = 1'b0;
         wake_phase_next = WAKE_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         wake_phase_reg <= WAKE_IDLE;
      else
         wake_phase_reg <= wake_phase_next;
   end

   // window opens once the first dominant phase has qualified
   always_ff @(posedge clk)
   begin
      if (reset || wake_phase_next == WAKE_IDLE)
         wake_win_reg <= CNT_ZERO;
      else if (wake_win_reg < WAKE_TO_CYC)
         wake_win_reg <= wake_win_reg + CNT_ONE;
   end

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk)
   begin
      if (reset)
         bus_wake_flag <= 1'b0;
      else if (wake_detect)
         bus_wake_flag <= 1'b1;
      else if (bus_wake_clear)
         bus_wake_flag <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         transceiver_fault_event <= 1'b0;
      else if (fault_hit && transceiver_fault_enable)
         transceiver_fault_event <= 1'b1;
      else if (fault_event_clear)
         transceiver_fault_event <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         ctrl_reg <= CTRL_RESET;
      else if (reg_write && reg_addr == CAN_MODE_CONTROL_ADDR)
         ctrl_reg <= reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         reg_rdata <= READ_ZERO;
      else if (reg_addr == CAN_MODE_CONTROL_ADDR)
         reg_rdata <= ctrl_reg;
      else if (reg_addr == TRANSCEIVER_STATUS_ADDR)
      begin
         reg_rdata <= READ_ZERO;
         reg_rdata[STAT_ACTIVE_BIT] <= (mode_reg == MODE_ACTIVE);
         reg_rdata[STAT_SILENCE_BIT] <= bus_silence_status;
         reg_rdata[STAT_SUPPLY_BIT] <= supply_low_status;
         reg_rdata[STAT_TIMEOUT_BIT] <= tx_timeout_status;
      end
      else
         reg_rdata <= READ_ZERO;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trx_mode <= MODE_OFF;
         tx_drive_dominant <= 1'b0;
         rxd_out <= 1'b1;
         bias_half_supply <= 1'b0;
         bus_floating <= 1'b1;
      end
      else
      begin
         trx_mode <= mode_next;
         tx_drive_dominant <= (mode_next == MODE_ACTIVE) && !txd_s && !tx_timeout_hit;
         bias_half_supply <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_LISTEN)
                             || (mode_next == MODE_OFFLINE_BIAS);
         bus_floating <= (mode_next == MODE_OFF);
         if (mode_reg == MODE_ACTIVE || mode_reg == MODE_LISTEN)
            rxd_out <= !bus_s;
         else if ((mode_reg == MODE_OFFLINE || mode_reg == MODE_OFFLINE_BIAS)
                  && (chip_normal || chip_mode_code == CHIP_STANDBY))
            rxd_out <= !(event_pending || wake_detect);
         else
            rxd_out <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_off_on_chip_dead: assert property (off_cond |=> mode_reg == MODE_OFF)
      else $error("transceiver not off after off condition");
   a_off_exit_offline: assert property ((mode_reg == MODE_OFF && chip_mode_code == CHIP_RESET && vbat_rec_s
      && !vbat_uv_s) |=> mode_reg == MODE_OFFLINE)
      else $error("off mode did not resume in offline");
   a_status_active_bit: assert property ((reg_addr == TRANSCEIVER_STATUS_ADDR) |=>
      reg_rdata[STAT_ACTIVE_BIT] == ($past(mode_reg) == MODE_ACTIVE))
      else $error("active status bit disagrees with mode");
   a_tx_timeout_hit: assert property (tx_timeout_hit |=> tx_timeout_status && mode_reg != MODE_ACTIVE
      && !tx_drive_dominant)
      else $error("dominant timeout not handled");
   a_tx_timer_clear: assert property (txd_s |=> tx_dom_cnt_reg == CNT_ZERO)
      else $error("dominant timer not cleared by txd high");
   a_wake_only_armed: assert property (!wake_armed |=> wake_phase_reg == WAKE_IDLE)
      else $error("wake filter running while not armed");
   a_wake_sets_flag: assert property (wake_detect && !off_cond && chip_normal
      |=> bus_wake_flag && mode_reg == MODE_OFFLINE_BIAS && !rxd_out)
      else $error("wake did not set flag or pull rxd low");
   a_bias_to_offline: assert property ((mode_reg == MODE_OFFLINE_BIAS && bus_silence_status && !off_cond
      && !(chip_normal && transceiver_mode_select != SEL_OFFLINE)) |=> mode_reg == MODE_OFFLINE)
      else $error("offline bias did not return to offline on silence");
   a_select_gated: assert property ((!chip_normal && mode_reg == MODE_ACTIVE) |=> mode_reg != MODE_ACTIVE)
      else $error("active kept outside normal state");
   a_supply_low_sel: assert property ((transceiver_mode_select != SEL_ACTIVE_UV) |=> !supply_low_status)
      else $error("supply low flag outside select 01");
   a_event_rxd_low: assert property ((mode_reg == MODE_OFFLINE && chip_normal && event_pending) |=> !rxd_out)
      else $error("pending event not shown on rxd");
endmodule : can_trx_mode_control

// file: verif/can_mcu_model.sv
`timescale 1ns/1ps
module can_mcu_model (
   input wire logic clk,
   input wire logic rxd_out,
   output logic txd
);
   int rxd_falls;
   logic rxd_prev;
   // idle recessive, as the pin pull-up would leave it
   initial txd = 1'b1;
   initial rxd_falls = 0;
   initial rxd_prev = 1'b1;
   // counts alerts the controller would take as wake or event interrupts
   always @(posedge clk)
   begin
      if (rxd_prev && !rxd_out)
         rxd_falls <= rxd_falls + 1;
      rxd_prev <= rxd_out;
   end
   task automatic set_txd(input logic v);
      @(negedge clk);
      txd = v;
   endtask : set_txd
   // a stuck controller holding dominant for a while
   task automatic hold_dominant(input int cycles);
      set_txd(1'b0);
      repeat (cycles) @(negedge clk);
      txd = 1'b1;
   endtask : hold_dominant
endmodule : can_mcu_model

// file: verif/tb.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("Error %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb;
   import can_trx_pkg::*;
   logic clk, reset, other_dom, v1_below_90, v1_below_reset, vbat_undervoltage, vbat_recovered;
   logic bus_wake_enable, transceiver_fault_enable, bus_wake_clear, fault_event_clear, reg_write;
   logic [2:0] chip_mode_code;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   wire logic bus_dominant, txd;
   trx_mode_t trx_mode;
   logic tx_drive_dominant, rxd_out, bias_half_supply, bus_floating, bus_wake_flag, transceiver_fault_event;
   int mismatches = 0;
   int n_tests = 0;
   // wired bus: any node driving dominant wins
   assign bus_dominant = other_dom | tx_drive_dominant;
   can_trx_mode_control #(.SILENCE_NS(2000), .WAKE_TO_NS(4000), .WAKE_DOM_NS(200), .WAKE_REC_NS(200),
      .TX_DOM_NS(1000)) dut (.clk(clk), .reset(reset), .chip_mode_code(chip_mode_code),
      .bus_dominant(bus_dominant), .txd(txd), .v1_below_90(v1_below_90), .v1_below_reset(v1_below_reset),
      .vbat_undervoltage(vbat_undervoltage), .vbat_recovered(vbat_recovered), .bus_wake_enable(bus_wake_enable),
      .transceiver_fault_enable(transceiver_fault_enable), .bus_wake_clear(bus_wake_clear),
      .fault_event_clear(fault_event_clear), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .trx_mode(trx_mode), .tx_drive_dominant(tx_drive_dominant), .rxd_out(rxd_out),
      .bias_half_supply(bias_half_supply), .bus_floating(bus_floating), .bus_wake_flag(bus_wake_flag),
      .transceiver_fault_event(transceiver_fault_event));
   can_mcu_model mcu (.clk(clk), .rxd_out(rxd_out), .txd(txd));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task test_done;
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic set_supply(input logic v90, input logic vrst, input logic vuv, input logic vrec);
      v1_below_90 = v90;
      v1_below_reset = vrst;
      vbat_undervoltage = vuv;
      vbat_recovered = vrec;
   endtask : set_supply
   task automatic set_ctl(input logic [2:0] chip, input logic wake_en, input logic fault_en);
      chip_mode_code = chip;
      bus_wake_enable = wake_en;
      transceiver_fault_enable = fault_en;
   endtask : set_ctl
   task automatic clear_events(input logic wake, input logic fault);
      bus_wake_clear = wake;
      fault_event_clear = fault;
      @(negedge clk);
      bus_wake_clear = 1'b0;
      fault_event_clear = 1'b0;
      @(negedge clk);
   endtask : clear_events
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = v;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic wait_mode(input trx_mode_t m, input int lim);
      for (int i = 0; i < lim && trx_mode !== m; i++)
         @(negedge clk);
      `CHECK("trx_mode", m, trx_mode)
   endtask : wait_mode
   task automatic pulse(input int dom1, input int rec, input int dom2);
      other_dom = 1'b1;
      repeat (dom1) @(negedge clk);
      other_dom = 1'b0;
      repeat (rec) @(negedge clk);
      other_dom = 1'b1;
      repeat (dom2) @(negedge clk);
      other_dom = 1'b0;
   endtask : pulse
   task t_reset_regs;
      wait_mode(MODE_OFFLINE, 10);
      repeat (100) @(negedge clk);
      rd(TRANSCEIVER_STATUS_ADDR);
      `CHECK("status idle", 8'h08, d)
      rd(CAN_MODE_CONTROL_ADDR);
      `CHECK("control reset", CTRL_RESET, d)
      rd(8'h21);
      `CHECK("unmapped", READ_ZERO, d)
   endtask : t_reset_regs
   task automatic t_select;
      logic [1:0] sel [4] = '{SEL_ACTIVE_UV, SEL_LISTEN, SEL_ACTIVE_RST, SEL_OFFLINE};
      trx_mode_t exp [4] = '{MODE_ACTIVE, MODE_LISTEN, MODE_ACTIVE, MODE_OFFLINE};
      for (int i = 0; i < 4; i++)
      begin
         wr(CAN_MODE_CONTROL_ADDR, {6'h00, sel[i]});
         wait_mode(exp[i], 10);
         rd(TRANSCEIVER_STATUS_ADDR);
         `CHECK("active bit", exp[i] == MODE_ACTIVE, d[STAT_ACTIVE_BIT])
         `CHECK("bias", exp[i] != MODE_OFFLINE, bias_half_supply)
      end
   endtask : t_select
   task t_standby;
      wr(CAN_MODE_CONTROL_ADDR, 8'h01);
      wait_mode(MODE_ACTIVE, 10);
      set_ctl(CHIP_STANDBY, 1'b0, 1'b0);
      wait_mode(MODE_OFFLINE, 200);
      wr(CAN_MODE_CONTROL_ADDR, 8'h03);
      repeat (10) @(negedge clk);
      `CHECK("standby mode", MODE_OFFLINE, trx_mode)
      set_ctl(CHIP_NORMAL, 1'b0, 1'b0);
      wait_mode(MODE_LISTEN, 10);
   endtask : t_standby
   task t_txd_timeout;
      set_ctl(CHIP_NORMAL, 1'b0, 1'b1);
      wr(CAN_MODE_CONTROL_ADDR, 8'h01);
      wait_mode(MODE_ACTIVE, 10);
      mcu.hold_dominant(30);
      repeat (3) @(negedge clk);
      mcu.hold_dominant(30);
      repeat (4) @(negedge clk);
      `CHECK("short dominant", MODE_ACTIVE, trx_mode)
      mcu.set_txd(1'b0);
      wait_mode(MODE_LISTEN, 60);
      `CHECK("tx released", 1'b0, tx_drive_dominant)
      `CHECK("fault event", 1'b1, transceiver_fault_event)
      rd(TRANSCEIVER_STATUS_ADDR);
      `CHECK("timeout bits", 2'b01, {d[STAT_ACTIVE_BIT], d[STAT_TIMEOUT_BIT]})
      mcu.set_txd(1'b1);
      wait_mode(MODE_ACTIVE, 10);
      clear_events(1'b0, 1'b1);
      `CHECK("fault cleared", 1'b0, transceiver_fault_event)
   endtask : t_txd_timeout
   task t_txd_low_request;
      wr(CAN_MODE_CONTROL_ADDR, 8'h00);
      wait_mode(MODE_OFFLINE, 200);
      mcu.set_txd(1'b0);
      wr(CAN_MODE_CONTROL_ADDR, 8'h01);
      wait_mode(MODE_LISTEN, 10);
      repeat (60) @(negedge clk);
      `CHECK("txd held low", MODE_LISTEN, trx_mode)
      mcu.set_txd(1'b1);
      wait_mode(MODE_ACTIVE, 10);
   endtask : t_txd_low_request
   task t_undervoltage;
      set_supply(1'b1, 1'b0, 1'b0, 1'b1);
      wait_mode(MODE_OFFLINE_BIAS, 200);
      rd(TRANSCEIVER_STATUS_ADDR);
      `CHECK("supply low bit", 1'b1, d[STAT_SUPPLY_BIT])
      `CHECK("uv fault", 1'b1, transceiver_fault_event)
      set_supply(1'b0, 1'b0, 1'b0, 1'b1);
      wait_mode(MODE_ACTIVE, 10);
      wr(CAN_MODE_CONTROL_ADDR, 8'h02);
      set_supply(1'b1, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      `CHECK("select 10 ignores 90", MODE_ACTIVE, trx_mode)
      set_supply(1'b1, 1'b1, 1'b0, 1'b1);
      wait_mode(MODE_OFFLINE_BIAS, 200);
      set_supply(1'b0, 1'b0, 1'b0, 1'b1);
      wait_mode(MODE_ACTIVE, 10);
      // leave no pending event behind, the wake checks rely on rxd idling high
      clear_events(1'b0, 1'b1);
      `CHECK("uv fault cleared", 1'b0, transceiver_fault_event)
   endtask : t_undervoltage
   task t_wake;
      int falls0;
      wr(CAN_MODE_CONTROL_ADDR, 8'h00);
      wait_mode(MODE_OFFLINE, 200);
      pulse(12, 12, 12);
      `CHECK("wake disabled", 1'b0, bus_wake_flag)
      wait_mode(MODE_OFFLINE, 200);
      set_ctl(CHIP_NORMAL, 1'b1, 1'b1);
      pulse(12, 4, 12);
      // let the wake window of the rejected pattern run out before the next one
      repeat (200) @(negedge clk);
      wait_mode(MODE_OFFLINE, 200);
      `CHECK("short recessive", 1'b0, bus_wake_flag)
      `CHECK("rxd idle", 1'b1, rxd_out)
      falls0 = mcu.rxd_falls;
      pulse(12, 12, 12);
      wait_mode(MODE_OFFLINE_BIAS, 5);
      `CHECK("wake flag", 1'b1, bus_wake_flag)
      `CHECK("rxd alert", 1'b0, rxd_out)
      wait_mode(MODE_OFFLINE, 200);
      `CHECK("rxd held", 1'b0, rxd_out)
      `CHECK("mcu alerted", 1, mcu.rxd_falls > falls0)
      clear_events(1'b1, 1'b0);
      `CHECK("wake cleared", 1'b0, bus_wake_flag)
      `CHECK("rxd released", 1'b1, rxd_out)
   endtask : t_wake
   task t_off;
      set_supply(1'b0, 1'b0, 1'b1, 1'b0);
      wait_mode(MODE_OFF, 10);
      `CHECK("floating", 1'b1, bus_floating)
      set_supply(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (10) @(negedge clk);
      `CHECK("no recovery", MODE_OFF, trx_mode)
      set_supply(1'b0, 1'b0, 1'b0, 1'b1);
      wait_mode(MODE_OFFLINE, 10);
      set_ctl(CHIP_OVERTEMP, 1'b1, 1'b1);
      wait_mode(MODE_OFF, 10);
      set_ctl(CHIP_RESET, 1'b1, 1'b1);
      wait_mode(MODE_OFFLINE, 10);
      set_ctl(CHIP_NORMAL, 1'b1, 1'b1);
   endtask : t_off
   initial
   begin
      reset = 1'b1;
      other_dom = 1'b0;
      reg_write = 1'b0;
      bus_wake_clear = 1'b0;
      fault_event_clear = 1'b0;
      set_supply(1'b0, 1'b0, 1'b0, 1'b1);
      set_ctl(CHIP_NORMAL, 1'b0, 1'b0);
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      t_reset_regs();
      t_select();
      t_standby();
      t_txd_timeout();
      t_txd_low_request();
      t_undervoltage();
      t_wake();
      t_off();
      test_done();
   end
   // the run needs about a thousand cycles; this cuts a hang short
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule : tb
